/* File: dv/cdi_host_model.sv */
module cdi_host_model (
   input  wire logic        clk,
   output logic      [3:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned timeouts = 0;
   initial begin
      avs_address    = 4'h0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'h0;
   end
   // One access; a wait beyond 50 cycles is counted, not hung on
   task automatic xfer(input logic rd, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q);
      int n = 0;
      @(posedge clk);
      avs_address    <= a;
      avs_read       <= rd;
      avs_write      <= ~rd;
      avs_writedata  <= {24'h0, d};
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) timeouts++;
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      // Released lines must not keep showing the old value
      avs_writedata <= ~{24'h0, d};
      avs_address   <= ~a;
   endtask
endmodule

/* File: dv/cdi_instr_decoder_tb_top.sv */
module cdi_instr_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cdi_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        ce = 1'b1;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        scan_line = 1'b0;
   logic [4:0]  scan_col = 5'h00;
   cdi_scan_t   scan_out;
   logic        lum_on;
   cdi_mode_t   mode_out;
   logic [5:0]  shift_ofs;
   logic [31:0] q;
   int          mismatches = 0;
   int          check_count = 0;

   always #2 clk = ~clk;

   cdi_instr_decoder #(.BLINK_HALF_CYC(8)) i_cdi_instr_decoder (
      .clk(clk), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scan_line(scan_line), .scan_col(scan_col),
      .scan_out(scan_out), .lum_on(lum_on), .mode_out(mode_out), .shift_ofs(shift_ofs));

   cdi_host_model i_cdi_host_model (
      .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Extra edge so registered outputs have landed before they are looked at
   task automatic ins(input logic [7:0] d);
      i_cdi_host_model.xfer(1'b0, 4'h0, d, 4'hF, q);
      @(posedge clk);
   endtask
   task automatic dat(input logic [7:0] d);
      i_cdi_host_model.xfer(1'b0, 4'h4, d, 4'hF, q);
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a);
      i_cdi_host_model.xfer(1'b1, a, 8'h00, 4'hF, q);
   endtask
   task automatic chk_ac(input logic [6:0] e);
      rd(4'h0);
      chk("counter", {25'h0, e}, q);
   endtask
   task automatic count_full(output int n);
      n = 0;
      repeat (32) begin
         @(posedge clk);
         if (scan_out.full === 1'b1) n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      cdi_mode_t m;
      m = '0;
      m.incr = 1'b1;
      m.bus_width_sel = 1'b1;
      m.two_lines = 1'b1;
      chk("mode", 32'(m), 32'(mode_out));
      chk("shift", 32'h0, 32'(shift_ofs));
      chk_ac(7'h00);
      rd(4'h4);
      chk("space", 32'h20, q);
      chk_ac(7'h01);
      rd(4'hC);
      chk("unmapped", 32'h0, q);
   endtask
   task automatic t_entry;
      for (int i = 0; i < 4; i++) begin
         ins(8'h04 | 8'(i));
         chk("entry", 32'(i), {30'h0, mode_out.incr, mode_out.shift_en});
         chk_ac(7'h01);
      end
   endtask
   task automatic t_onoff;
      int n;
      for (int i = 0; i < 8; i++) begin
         ins(8'h08 | 8'(i));
         chk("onoff", 32'(i), {29'h0, mode_out.display_en, mode_out.cursor_en,
                               mode_out.blink_en});
      end
      ins(8'h0E);
      scan_col <= 5'h01;
      repeat (2) @(posedge clk);
      chk("scan", {21'h0, 3'b001, 8'h20}, 32'(scan_out));
      ins(8'h0F);
      count_full(n);
      chk("blink", 32'd16, 32'(n));
      ins(8'h08);
      count_full(n);
      chk("noblink", 32'd0, 32'(n));
      chk("blank", 32'h1, {31'h0, scan_out.blank});
   endtask
   task automatic t_func;
      logic [3:0] v;
      int         n;
      for (int i = 0; i < 16; i++) begin
         v = 4'(i);
         ins({3'b001, v[3:2], 1'b0, v[1:0]});
         chk("func", 32'(v), {28'h0, mode_out.bus_width_sel, mode_out.two_lines,
              mode_out.dim_level_hi, mode_out.dim_level_lo});
         repeat (4) @(posedge clk);
         n = 0;
         repeat (8) begin
            @(posedge clk);
            if (lum_on === 1'b1) n++;
         end
         chk("lum", 32'(2 * (4 - v[1:0])), 32'(n));
      end
      ins(8'h38);
   endtask
   task automatic t_ram;
      ins(8'h06);
      ins(8'hA7);
      chk_ac(7'h27);
      dat(8'h5A);
      chk_ac(7'h40);
      dat(8'hA5);
      ins(8'hA7);
      rd(4'h4);
      chk("ddrd0", 32'h5A, q);
      rd(4'h4);
      chk("ddrd1", 32'hA5, q);
      ins(8'hE7);
      dat(8'h11);
      chk_ac(7'h00);
      ins(8'h04);
      dat(8'h22);
      chk_ac(7'h67);
      ins(8'hC0);
      dat(8'h33);
      chk_ac(7'h27);
      ins(8'h80);
      rd(4'h4);
      chk("ddrd2", 32'h22, q);
      chk_ac(7'h67);
      ins(8'h06);
      ins(8'h7F);
      chk_ac(7'h3F);
      dat(8'h1F);
      chk_ac(7'h00);
      ins(8'h04);
      dat(8'h0E);
      chk_ac(7'h3F);
      ins(8'h40);
      rd(4'h4);
      chk("cgrd", 32'h0E, q);
   endtask
   task automatic t_shift;
      ins(8'h07);
      ins(8'h80);
      dat(8'h33);
      chk("ofs_wr", 32'h1, 32'(shift_ofs));
      ins(8'h80);
      rd(4'h4);
      @(posedge clk);
      chk("ofs_rd", 32'h1, 32'(shift_ofs));
      ins(8'h40);
      dat(8'h44);
      chk("ofs_cg", 32'h1, 32'(shift_ofs));
      ins(8'h05);
      ins(8'h85);
      dat(8'h55);
      chk("ofs_dec", 32'h0, 32'(shift_ofs));
      ins(8'h10);
      chk_ac(7'h03);
      ins(8'h14);
      chk_ac(7'h04);
      ins(8'h18);
      chk("ofs_l", 32'h1, 32'(shift_ofs));
      ins(8'h1F);
      chk("ofs_r", 32'h0, 32'(shift_ofs));
      ins(8'h45);
      ins(8'h17);
      chk_ac(7'h06);
      rd(4'h8);
      chk("in_glyph", 32'h0, {31'h0, q[9]});
   endtask
   // Code 3 makes the dimming output toggle, so a frozen one is visible
   task automatic t_ce;
      logic l0;
      int   n;
      ins(8'h3B);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      l0 = lum_on;
      n = 0;
      repeat (8) begin
         @(posedge clk);
         if (lum_on === l0) n++;
      end
      chk("ce_freeze", 32'd8, 32'(n));
      ce <= 1'b1;
      ins(8'h38);
      chk_ac(7'h06);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      mismatches += int'(i_cdi_host_model.timeouts);
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_entry();
      t_onoff();
      t_func();
      t_ram();
      t_shift();
      t_ce();
      wrap_up();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
endmodule

/* File: src/cdi_instr_decoder.sv */
// Contract
// - Address counter steps down after RAM access when direction bit is 0, else up.
// - Auto-shift moves display per char-RAM write; never on reads or glyph access.
// - Entry mode opcode 000001xx carries step direction and auto-shift enable.
// - Entry, on/off, function set, counter read leave RAMs and counter alone.
// - Display on/off opcode 00001xxx carries display, cursor, blink enables.
// - Display disabled blanks everything; enabled shows char RAM contents.
// - Cursor enable draws eighth pixel row at the counter's position.
// - Blink alternates cursor character with all-on pattern near 1 Hz, half duty.
// - Shift opcode 0001xxxx: bit 3 display/cursor, bit 2 direction, no RAM access.
// - Shift steps counter by direction; select bit also shifts the display.
// - After a shift instruction the counter addresses char RAM.
// - Function set opcode 001xxxxx: bus width, line count, brightness code.
// - Bus width 0 means 4-bit upper lines, 1 means 8-bit transfers; code only stores the bit, every write takes a whole byte.
// - Line count 0 selects one line, 1 selects two lines.
// - Brightness code 00..11 gives 100, 75, 50, 25 percent luminance.
// - Opcode 01 loads 6-bit glyph address; following data goes to glyph RAM.
// - Bit 7 set loads 7-bit char address; following data goes to char RAM.
// - Instruction read returns busy flag 0 on bit 7 and counter below.
// - Instructions and data accepted back to back with no execution delay.
// - Data write stores byte at counter in selected RAM, then steps; only char RAM writes with auto-shift on also shift.
// - Data read returns byte at counter in selected RAM, then steps.
// - Char RAM stepping wraps 27-40, 67-00 up and 40-27, 00-67 down.
// - Glyph RAM stepping wraps 3F-00 up and 00-3F down.
// - Reset fills char RAM with spaces and loads documented mode defaults.
//
// The address map and the Avalon-MM slave port were left to the implementer.
`include "cdi_params.svh"
module cdi_instr_decoder #(
   parameter int unsigned BLINK_HALF_CYC = `CDI_BLINK_HALF_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   ce,
   input  wire logic [`CDI_ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   scan_line,
   input  wire logic [4:0]             scan_col,
   output cdi_pkg::cdi_scan_t          scan_out,
   output logic                        lum_on,
   output cdi_pkg::cdi_mode_t          mode_out,
   output logic      [5:0]             shift_ofs
);
   import cdi_pkg::*;

   localparam logic [`CDI_CNT_W-1:0] BLINK_LAST = `CDI_CNT_W'(BLINK_HALF_CYC - 1);

   cdi_state_t st;
   cdi_state_t next_st;
   logic       acc;
   logic       hit_instr;
   logic       hit_data;
   logic       hit_cfg;
   logic [7:0] wbyte;

   ////////////////////////////////////////////////////////////////////////
   function automatic cdi_addr_t step_ac(input cdi_addr_t a,
                                         input logic glyph,
                                         input logic up);
      cdi_addr_t r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (glyph) begin
         r = {1'b0, r[5:0]};
      end else if (up && a == `CDI_DD_L1_END) begin
         r = `CDI_DD_L2_BEG;
      end else if (up && a == `CDI_DD_L2_END) begin
         r = `CDI_DD_L1_BEG;
      end else if (!up && a == `CDI_DD_L2_BEG) begin
         r = `CDI_DD_L1_END;
      end else if (!up && a == `CDI_DD_L1_BEG) begin
         r = `CDI_DD_L2_END;
      end
      return r;
   endfunction

   // Up means content moves left: position one shows the next address
   function automatic logic [5:0] ring_step(input logic [5:0] o,
                                            input logic up);
      logic [5:0] r;
      if (up) begin
         r = (o == `CDI_RING_LAST) ? 6'h00 : o + 6'h01;
      end else begin
         r = (o == 6'h00) ? `CDI_RING_LAST : o - 6'h01;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   assign hit_instr = (avs_address == `CDI_OFS_INSTR);
   assign hit_data  = (avs_address == `CDI_OFS_DATA);
   assign hit_cfg   = (avs_address == `CDI_OFS_CONFIG);
   // Request completes at the edge where waitrequest is seen low
   assign acc       = (avs_read || avs_write) && !st.bus_wait;
   assign wbyte     = avs_writedata[7:0];

   always_comb begin
      logic [31:0] rd;
      logic [31:0] cfg;
      logic [5:0]  idx;
      cdi_addr_t   sa;
      logic        here;
      logic        dark;
      rd   = '0;
      cfg  = '0;
      idx  = '0;
      sa   = '0;
      here = 1'b0;
      dark = 1'b0;
      next_st = st;

      cfg[`CDI_CFG_SHIFT_EN] = st.mode.shift_en;
      cfg[`CDI_CFG_INCR]     = st.mode.incr;
      cfg[`CDI_CFG_BLINK]    = st.mode.blink_en;
      cfg[`CDI_CFG_CURSOR]   = st.mode.cursor_en;
      cfg[`CDI_CFG_DISPLAY]  = st.mode.display_en;
      cfg[`CDI_CFG_LINES]    = st.mode.two_lines;
      cfg[`CDI_CFG_WIDTH]    = st.mode.bus_width_sel;
      cfg[`CDI_CFG_DIM_LO]   = st.mode.dim_level_lo;
      cfg[`CDI_CFG_DIM_HI]   = st.mode.dim_level_hi;
      cfg[`CDI_CFG_GLYPH]    = st.in_glyph;
      cfg[`CDI_CFG_OFS +: 6] = st.shift_ofs;

      // Read data is captured one cycle early; state cannot move meanwhile
      if (hit_instr) begin
         rd = {24'h000000, 1'b0, st.cursor_addr_counter};
      end else if (hit_data) begin
         rd = {24'h000000, st.in_glyph ?
               st.glyph_ram[st.cursor_addr_counter[5:0]] :
               st.char_code_ram[st.cursor_addr_counter]};
      end else if (hit_cfg) begin
         rd = cfg;
      end

      // One wait state per access, then waitrequest high again at once
      if ((avs_read || avs_write) && st.bus_wait) begin
         next_st.bus_wait = 1'b0;
         next_st.readdata = rd;
      end else begin
         next_st.bus_wait = 1'b1;
      end

      if (acc && avs_write && hit_instr && avs_byteenable[0]) begin
         if (wbyte[7]) begin
            next_st.cursor_addr_counter = wbyte[6:0];
            next_st.in_glyph = 1'b0;
         end else if (wbyte[6]) begin
            next_st.cursor_addr_counter = {1'b0, wbyte[5:0]};
            next_st.in_glyph = 1'b1;
         end else if (wbyte[5]) begin
            next_st.mode.bus_width_sel = wbyte[`CDI_FUN_DL];
            next_st.mode.two_lines = wbyte[`CDI_FUN_N];
            next_st.mode.dim_level_hi = wbyte[`CDI_FUN_BR1];
            next_st.mode.dim_level_lo = wbyte[`CDI_FUN_BR0];
         end else if (wbyte[4]) begin
            next_st.cursor_addr_counter =
               step_ac(st.cursor_addr_counter, 1'b0, wbyte[`CDI_SHF_RL]);
            next_st.in_glyph = 1'b0;
            if (wbyte[`CDI_SHF_SC]) begin
               next_st.shift_ofs = ring_step(st.shift_ofs, !wbyte[`CDI_SHF_RL]);
            end
         end else if (wbyte[3]) begin
            next_st.mode.display_en = wbyte[`CDI_DSP_D];
            next_st.mode.cursor_en = wbyte[`CDI_DSP_C];
            next_st.mode.blink_en = wbyte[`CDI_DSP_B];
         end else if (wbyte[2]) begin
            next_st.mode.incr = wbyte[`CDI_ENT_ID];
            next_st.mode.shift_en = wbyte[`CDI_ENT_S];
         end
         // Clear and home codes fall through as no-ops here
      end

      if (acc && avs_write && hit_data && avs_byteenable[0]) begin
         if (st.in_glyph) begin
            next_st.glyph_ram[st.cursor_addr_counter[5:0]] = wbyte;
         end else begin
            next_st.char_code_ram[st.cursor_addr_counter] = wbyte;
            if (st.mode.shift_en) begin
               next_st.shift_ofs = ring_step(st.shift_ofs, st.mode.incr);
            end
         end
         next_st.cursor_addr_counter =
            step_ac(st.cursor_addr_counter, st.in_glyph, st.mode.incr);
      end

      // Reads never shift the display
      if (acc && avs_read && hit_data) begin
         next_st.cursor_addr_counter =
            step_ac(st.cursor_addr_counter, st.in_glyph, st.mode.incr);
      end

      // Half period far beyond 4096 cycles, hence a parameter
      if (st.blink_cnt == BLINK_LAST) begin
         next_st.blink_cnt = '0;
         next_st.blink_phase = !st.blink_phase;
      end else begin
         next_st.blink_cnt = st.blink_cnt + `CDI_CNT_W'(1);
      end

      // Four-slot duty: code 0 lights four slots, code 3 only one
      next_st.lum_cnt = st.lum_cnt + 2'h1;
      next_st.lum_on = ({1'b0, st.lum_cnt} +
                        {1'b0, st.mode.dim_level_hi, st.mode.dim_level_lo})
                       < `CDI_LUM_STEPS;

      // Scan lookup: column plus shift offset, folded into the 40 ring
      idx = {1'b0, scan_col} + st.shift_ofs;
      if (idx > `CDI_RING_LAST) begin
         idx = idx - (`CDI_RING_LAST + 6'h01);
      end
      sa   = {scan_line, idx};
      here = !st.in_glyph && (st.cursor_addr_counter == sa);
      dark = !st.mode.display_en || (scan_line && !st.mode.two_lines);
      next_st.scan.code = st.char_code_ram[sa];
      next_st.scan.blank = dark;
      next_st.scan.cursor = st.mode.cursor_en && here && !dark;
      next_st.scan.full = st.mode.blink_en && st.blink_phase && here && !dark;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= CDI_RST_ST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign avs_readdata    = st.readdata;
   assign avs_waitrequest = st.bus_wait;
   assign scan_out        = st.scan;
   assign lum_on          = st.lum_on;
   assign mode_out        = st.mode;
   assign shift_ofs       = st.shift_ofs;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_dwrite;
      ce && acc && avs_write && hit_data && avs_byteenable[0];
   endsequence
   sequence s_dread;
      ce && acc && avs_read && hit_data;
   endsequence
   sequence s_iwrite;
      ce && acc && avs_write && hit_instr && avs_byteenable[0];
   endsequence
   sequence s_ddstep(logic up, cdi_addr_t from);
      !st.in_glyph && st.mode.incr == up && st.cursor_addr_counter == from;
   endsequence

   AST_WRAP_UP: assert property (
      s_dwrite ##0 s_ddstep(1'b1, `CDI_DD_L1_END)
      |=> st.cursor_addr_counter == `CDI_DD_L2_BEG)
      else $error("char address did not wrap 27 to 40");
   AST_WRAP_DOWN: assert property (
      s_dread ##0 s_ddstep(1'b0, `CDI_DD_L1_BEG)
      |=> st.cursor_addr_counter == `CDI_DD_L2_END)
      else $error("char address did not wrap 00 to 67");
   AST_GLYPH_WRAP: assert property (
      s_dwrite ##0 (st.in_glyph && st.mode.incr && st.cursor_addr_counter == 7'h3F)
      |=> st.cursor_addr_counter == 7'h00 && st.in_glyph)
      else $error("glyph address did not wrap 3F to 00");
   AST_SHIFT_WRITE: assert property (
      s_dwrite ##0 (!st.in_glyph && st.mode.shift_en && st.mode.incr &&
                    st.shift_ofs != `CDI_RING_LAST)
      |=> st.shift_ofs == $past(st.shift_ofs) + 6'h01)
      else $error("display did not shift left on write");
   AST_NO_SHIFT_READ: assert property (
      s_dread |=> $stable(st.shift_ofs))
      else $error("display shifted on a read");
   AST_ENTRY_KEEP: assert property (
      s_iwrite ##0 (wbyte[7:2] == 6'b000001)
      |=> $stable(st.cursor_addr_counter) && $stable(st.char_code_ram) &&
          $stable(st.glyph_ram) && st.mode.incr == $past(wbyte[1]))
      else $error("entry mode disturbed counter or RAM");
   AST_SHIFT_TO_CHAR: assert property (
      s_iwrite ##0 (wbyte[7:4] == 4'b0001) |=> !st.in_glyph)
      else $error("shift left counter on glyph RAM");
   AST_GLYPH_SET: assert property (
      s_iwrite ##0 (wbyte[7:6] == 2'b01)
      |=> st.in_glyph && st.cursor_addr_counter == {1'b0, $past(wbyte[5:0])})
      else $error("glyph address set failed");
   AST_STATUS_READ: assert property (
      ce && acc && avs_read && hit_instr
      |-> avs_readdata == {25'h0000000, st.cursor_addr_counter})
      else $error("status read wrong busy or counter");
   AST_ONE_WAIT: assert property (
      ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("access took more than one wait state");
endmodule

/* File: src/cdi_params.svh */
`ifndef CDI_PARAMS_SVH
`define CDI_PARAMS_SVH
`define CDI_ADDR_W        4
`define CDI_OFS_INSTR     4'h0
`define CDI_OFS_DATA      4'h4
`define CDI_OFS_CONFIG    4'h8
`define CDI_DD_DEPTH      128
`define CDI_CG_DEPTH      64
`define CDI_DD_L1_BEG     7'h00
`define CDI_DD_L1_END     7'h27
`define CDI_DD_L2_BEG     7'h40
`define CDI_DD_L2_END     7'h67
`define CDI_RING_LAST     6'h27
`define CDI_SPACE         8'h20
`define CDI_LUM_STEPS     3'h4
`define CDI_CLK_KHZ       250000
`define CDI_BLINK_HALF_MS 500
`define CDI_BLINK_HALF_CYC (`CDI_BLINK_HALF_MS * `CDI_CLK_KHZ)
`define CDI_CNT_W         27
`define CDI_ENT_ID        1
`define CDI_ENT_S         0
`define CDI_DSP_D         2
`define CDI_DSP_C         1
`define CDI_DSP_B         0
`define CDI_SHF_SC        3
`define CDI_SHF_RL        2
`define CDI_FUN_DL        4
`define CDI_FUN_N         3
`define CDI_FUN_BR1       1
`define CDI_FUN_BR0       0
`define CDI_CFG_SHIFT_EN  0
`define CDI_CFG_INCR      1
`define CDI_CFG_BLINK     2
`define CDI_CFG_CURSOR    3
`define CDI_CFG_DISPLAY   4
`define CDI_CFG_LINES     5
`define CDI_CFG_WIDTH     6
`define CDI_CFG_DIM_LO    7
`define CDI_CFG_DIM_HI    8
`define CDI_CFG_GLYPH     9
`define CDI_CFG_OFS       10
`endif

/* File: src/cdi_pkg.sv */
`include "cdi_params.svh"
package cdi_pkg;
   typedef logic [6:0] cdi_addr_t;

   typedef struct packed {
      logic incr;
      logic shift_en;
      logic display_en;
      logic cursor_en;
      logic blink_en;
      logic bus_width_sel;
      logic two_lines;
      logic dim_level_hi;
      logic dim_level_lo;
   } cdi_mode_t;

   typedef struct packed {
      logic       blank;
      logic       full;
      logic       cursor;
      logic [7:0] code;
   } cdi_scan_t;

   typedef struct packed {
      logic [`CDI_DD_DEPTH-1:0][7:0] char_code_ram;
      logic [`CDI_CG_DEPTH-1:0][7:0] glyph_ram;
      cdi_addr_t                     cursor_addr_counter;
      logic                          in_glyph;
      logic [5:0]                    shift_ofs;
      cdi_mode_t                     mode;
      logic                          bus_wait;
      logic [31:0]                   readdata;
      logic [`CDI_CNT_W-1:0]         blink_cnt;
      logic                          blink_phase;
      logic [1:0]                    lum_cnt;
      logic                          lum_on;
      cdi_scan_t                     scan;
   } cdi_state_t;

   localparam cdi_mode_t CDI_RST_MODE = '{incr: 1'b1, bus_width_sel: 1'b1,
                                          two_lines: 1'b1, default: 1'b0};
   localparam cdi_state_t CDI_RST_ST = '{
      char_code_ram: {`CDI_DD_DEPTH{`CDI_SPACE}},
      mode:          CDI_RST_MODE,
      bus_wait:      1'b1,
      default:       '0};
endpackage
